// ### verilog/stc_consts.svh
// constants of the sysref timing calibration block: offsets, fields, resets, limits
// assumes inclusion by bare name from every file that needs a figure
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH

`define STC_ADDR_W          12
`define STC_ADDR_CFG        12'h02b1
`define STC_ADDR_STATUS     12'h02b2

`define STC_CFG_RESET       8'h05
`define STC_CFG_AVG_MSB     3
`define STC_CFG_AVG_LSB     2
`define STC_CFG_HDUR_MSB    1
`define STC_CFG_HDUR_LSB    0

`define STC_STAT_DONE_BIT   17
`define STC_RES_INV_BIT     16
`define STC_RES_COARSE_MSB  15
`define STC_RES_COARSE_LSB  8
`define STC_RES_FINE_MSB    7
`define STC_RES_FINE_LSB    0
`define STC_RESULT_RESET    17'h0_0000

// longest sysref period per accumulation code, in sampling clock cycles
`define STC_MAXPER_0        16'h0080
`define STC_MAXPER_1        16'h0680
`define STC_MAXPER_2        16'h1e80
`define STC_MAXPER_3        16'h7e80

// time bound factor 384 * 19, in sampling clock cycles
`define STC_CAL_SCALE       32'h0000_1c80

`endif

// ### verilog/stc_pkg.sv
// types of the sysref timing calibration block
// assumes no surrounding package; all users name it explicitly
package stc_pkg;

    typedef enum logic [1:0] {
        STC_IDLE   = 2'b00,
        STC_ARM    = 2'b01,
        STC_ACCUM  = 2'b10
    } stc_state_t;

    typedef logic [16:0] stc_delay_t;

endpackage

// ### verilog/stc_cal_if.sv
// carrier between the register side and the measurement engine
// assumes both ends on the same clock
`timescale 1ns/100ps
interface stc_cal_if;
    logic                start;     // one-cycle start of a sequence
    logic                abort;     // level, stops the engine
    logic [1:0]          avg_code;  // averaging code
    logic [1:0]          hdur_code; // accumulation code
    logic                sysref;    // synchronised sysref level
    logic                finished;  // one-cycle pulse, result valid
    logic                failed;    // one-cycle pulse, period too long
    logic                busy;      // engine running
    stc_pkg::stc_delay_t result;    // computed delay setting

    modport ctrl (output start, abort, avg_code, hdur_code, sysref,
                  input finished, failed, busy, result);
    modport eng  (input start, abort, avg_code, hdur_code, sysref,
                  output finished, failed, busy, result);
endinterface

// ### verilog/stc_engine.sv
// measurement engine: per measurement waits for a sysref rising edge, then
// counts high samples over one accumulation window, and averages the counts
// assumes sysref already synchronised to this clock
`timescale 1ns/100ps
`include "stc_consts.svh"
module stc_engine (
    input  wire logic  clk_i,   // sampling clock
    input  wire logic  rst_n_i, // async reset, active low
    stc_cal_if.eng     cal      // link to the register side
);
    stc_pkg::stc_state_t state_q, state_d;
    logic [1:0]          avg_q, avg_d, hdur_q, hdur_d;
    logic [15:0]         wait_q, wait_d;
    logic [8:0]          acc_q, acc_d, high_q, high_d, meas_q, meas_d;
    logic [16:0]         sum_q, sum_d;
    logic                prev_q, prev_d, busy_q, busy_d, fin_q, fin_d, fail_q, fail_d;
    stc_pkg::stc_delay_t res_q, res_d;
    logic [15:0]         max_per;
    logic [8:0]          win_len, meas_n, mean, high_nx;
    logic [16:0]         sum_nx;
    logic [3:0]          sh;
    logic [24:0]         frac;

    always_comb begin
        case (hdur_q)
            2'd0:    max_per = `STC_MAXPER_0;
            2'd1:    max_per = `STC_MAXPER_1;
            2'd2:    max_per = `STC_MAXPER_2;
            default: max_per = `STC_MAXPER_3;
        endcase
        win_len = 9'd4 << {hdur_q, 1'b0};
        meas_n  = 9'd4 << {avg_q, 1'b0};
        high_nx = high_q + {8'd0, prev_q};
        sum_nx  = sum_q + {8'd0, high_nx};
        sh      = {1'b0, avg_q, 1'b0} + 4'd2;
        mean    = 9'(sum_nx >> sh);
        frac    = {8'd0, sum_nx} << (4'd8 - sh);
    end

    always_comb begin
        state_d = state_q;
        avg_d   = avg_q;
        hdur_d  = hdur_q;
        wait_d  = wait_q;
        acc_d   = acc_q;
        high_d  = high_q;
        meas_d  = meas_q;
        sum_d   = sum_q;
        prev_d  = cal.sysref;
        busy_d  = busy_q;
        fin_d   = 1'b0;
        fail_d  = 1'b0;
        res_d   = res_q;
        case (state_q)
            stc_pkg::STC_IDLE: begin
                if (cal.start && !cal.abort) begin
                    avg_d   = cal.avg_code;
                    hdur_d  = cal.hdur_code;
                    wait_d  = 16'h0000;
                    meas_d  = 9'd0;
                    sum_d   = 17'h0_0000;
                    busy_d  = 1'b1;
                    state_d = stc_pkg::STC_ARM;
                end
            end
            stc_pkg::STC_ARM: begin
                if (cal.sysref && !prev_q) begin
                    acc_d   = 9'd0;
                    high_d  = 9'd0;
                    wait_d  = 16'h0000;
                    state_d = stc_pkg::STC_ACCUM;
                end else if (wait_q >= max_per) begin
                    // no edge inside the supported period: give up
                    fail_d  = 1'b1;
                    busy_d  = 1'b0;
                    state_d = stc_pkg::STC_IDLE;
                end else begin
                    wait_d = wait_q + 16'h0001;
                end
            end
            stc_pkg::STC_ACCUM: begin
                high_d = high_nx;
                acc_d  = acc_q + 9'd1;
                wait_d = wait_q + 16'h0001;
                if (acc_q == win_len - 9'd1) begin
                    sum_d  = sum_nx;
                    meas_d = meas_q + 9'd1;
                    if (meas_q == meas_n - 9'd1) begin
                        res_d[`STC_RES_INV_BIT] = ({mean, 1'b0} > {1'b0, win_len});
                        res_d[`STC_RES_COARSE_MSB:`STC_RES_COARSE_LSB] =
                            mean[8] ? 8'hff : mean[7:0];
                        res_d[`STC_RES_FINE_MSB:`STC_RES_FINE_LSB] = frac[7:0];
                        fin_d   = 1'b1;
                        busy_d  = 1'b0;
                        state_d = stc_pkg::STC_IDLE;
                    end else begin
                        state_d = stc_pkg::STC_ARM;
                    end
                end
            end
            default: begin
                busy_d  = 1'b0;
                state_d = stc_pkg::STC_IDLE;
            end
        endcase
        if (cal.abort && state_q != stc_pkg::STC_IDLE) begin
            busy_d  = 1'b0;
            fin_d   = 1'b0;
            state_d = stc_pkg::STC_IDLE;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= stc_pkg::STC_IDLE;
            avg_q   <= 2'd0;
            hdur_q  <= 2'd0;
            wait_q  <= 16'h0000;
            acc_q   <= 9'd0;
            high_q  <= 9'd0;
            meas_q  <= 9'd0;
            sum_q   <= 17'h0_0000;
            prev_q  <= 1'b0;
            busy_q  <= 1'b0;
            fin_q   <= 1'b0;
            fail_q  <= 1'b0;
            res_q   <= `STC_RESULT_RESET;
        end else begin
            state_q <= state_d;
            avg_q   <= avg_d;
            hdur_q  <= hdur_d;
            wait_q  <= wait_d;
            acc_q   <= acc_d;
            high_q  <= high_d;
            meas_q  <= meas_d;
            sum_q   <= sum_d;
            prev_q  <= prev_d;
            busy_q  <= busy_d;
            fin_q   <= fin_d;
            fail_q  <= fail_d;
            res_q   <= res_d;
        end
    end

    assign cal.finished = fin_q;
    assign cal.failed   = fail_q;
    assign cal.busy     = busy_q;
    assign cal.result   = res_q;
endmodule // stc_engine

// ### verilog/stc_top.sv
// sysref timing calibration: configuration and status registers, start on
// enable rise, time bound supervision, and delay selection auto/manual
// assumes enable and manual delay come from neighbouring registers on this clock
`timescale 1ns/100ps
`include "stc_consts.svh"
// Behaviour
// - averaging code picks 4, 16, 64, 256 measurements
// - accumulation code picks window and longest period
// - too long sysref period makes calibration fail
// - calibration ends within 384*19*4^(avg+hdur+2) cycles
// - configuration reads 0x05 after reset
// - done bit high only when enabled and finished
// - status low bits carry computed delay setting
// - result bit 16 tells clock inversion
// - result coarse in 15:8, fine in 7:0
// - status read-only, 24 bits, 23:18 reserved
// - enable rising edge starts a new sequence
// - enabled uses result, disabled uses manual delay
module stc_top #(
    parameter logic [31:0] CAL_SCALE = `STC_CAL_SCALE // time bound factor, cycles
) (
    input  wire logic                   CLOCK_I,         // sampling clock, 25 MHz
    input  wire logic                   RESET_N_I,       // async reset, active low
    input  wire logic                   SYSREF_I,        // sysref pin, asynchronous
    input  wire logic                   CAL_ENABLE_I,    // calibration enable level
    input  wire logic [16:0]            MANUAL_DELAY_I,  // manual delay setting
    input  wire logic [`STC_ADDR_W-1:0] REG_ADDR_I,      // register address
    input  wire logic                   REG_WR_I,        // write strobe
    input  wire logic [7:0]             REG_WDATA_I,     // write data
    input  wire logic                   REG_RD_I,        // read strobe
    output logic      [23:0]            REG_RDATA_O,     // read data, one cycle later
    output logic                        REG_RVALID_O,    // read data valid pulse
    output logic      [16:0]            DELAY_O,         // delay applied to the clock
    output logic                        CAL_BUSY_O,      // calibration running
    output logic                        CAL_FAILED_O     // last sequence failed
);
    stc_cal_if cal ();

    // configuration register
    logic [1:0] cal_average_count_q, cal_average_count_d;
    logic [1:0] cal_accumulation_length_q, cal_accumulation_length_d;

    always_comb begin
        cal_average_count_d       = cal_average_count_q;
        cal_accumulation_length_d = cal_accumulation_length_q;
        if (REG_WR_I && REG_ADDR_I == `STC_ADDR_CFG) begin
            cal_average_count_d       = REG_WDATA_I[`STC_CFG_AVG_MSB:`STC_CFG_AVG_LSB];
            cal_accumulation_length_d = REG_WDATA_I[`STC_CFG_HDUR_MSB:`STC_CFG_HDUR_LSB];
        end
    end

    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cal_average_count_q       <= 2'(`STC_CFG_RESET >> `STC_CFG_AVG_LSB);
            cal_accumulation_length_q <= 2'(`STC_CFG_RESET >> `STC_CFG_HDUR_LSB);
        end else begin
            cal_average_count_q       <= cal_average_count_d;
            cal_accumulation_length_q <= cal_accumulation_length_d;
        end
    end

    // sysref pin synchroniser
    logic sysref_meta_q, sysref_sync_q;

    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sysref_meta_q <= 1'b0;
            sysref_sync_q <= 1'b0;
        end else begin
            sysref_meta_q <= SYSREF_I;
            sysref_sync_q <= sysref_meta_q;
        end
    end

    // enable edge, completion, failure, time bound
    logic        enable_prev_q, enable_prev_d;
    logic        cal_complete_flag_q, cal_complete_flag_d;
    logic        failed_q, failed_d;
    logic [31:0] budget_q, budget_d;
    logic [31:0] elapsed_q, elapsed_d;
    logic        start_pulse, over_budget;
    logic [4:0]  budget_shift;

    assign start_pulse  = CAL_ENABLE_I && !enable_prev_q;
    // four bits for the exponent: codes 3 and 3 give 8, which three bits would wrap
    assign budget_shift = {({2'b00, cal_average_count_q}
                          + {2'b00, cal_accumulation_length_q} + 4'd2), 1'b0};
    // a sequence that outlives its bound is cut off and reported as failed
    assign over_budget  = cal.busy && (elapsed_q >= budget_q);

    always_comb begin
        enable_prev_d       = CAL_ENABLE_I;
        cal_complete_flag_d = cal_complete_flag_q;
        failed_d            = failed_q;
        budget_d            = budget_q;
        elapsed_d           = elapsed_q;
        if (start_pulse) begin
            // new sequence: earlier completion must not be reported
            cal_complete_flag_d = 1'b0;
            failed_d            = 1'b0;
            budget_d            = CAL_SCALE << budget_shift;
            elapsed_d           = 32'h0000_0000;
        end else if (cal.busy) begin
            elapsed_d = elapsed_q + 32'h0000_0001;
        end
        if (cal.finished) begin
            cal_complete_flag_d = 1'b1;
        end
        if (cal.failed || over_budget) begin
            failed_d = 1'b1;
        end
        if (!CAL_ENABLE_I) begin
            cal_complete_flag_d = 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            enable_prev_q       <= 1'b0;
            cal_complete_flag_q <= 1'b0;
            failed_q            <= 1'b0;
            budget_q            <= 32'h0000_0000;
            elapsed_q           <= 32'h0000_0000;
        end else begin
            enable_prev_q       <= enable_prev_d;
            cal_complete_flag_q <= cal_complete_flag_d;
            failed_q            <= failed_d;
            budget_q            <= budget_d;
            elapsed_q           <= elapsed_d;
        end
    end

    assign cal.start     = start_pulse;
    assign cal.abort     = !CAL_ENABLE_I || over_budget;
    assign cal.avg_code  = cal_average_count_q;
    assign cal.hdur_code = cal_accumulation_length_q;
    assign cal.sysref    = sysref_sync_q;

    stc_engine u_engine (
        .clk_i   (CLOCK_I),
        .rst_n_i (RESET_N_I),
        .cal     (cal.eng)
    );

    // register read port and registered outputs
    logic [23:0] rdata_q, rdata_d;
    logic        rvalid_q, rvalid_d;
    logic [16:0] delay_q, delay_d;
    logic        busy_q, busy_d;
    logic        fail_out_q, fail_out_d;
    logic [23:0] status_word;

    always_comb begin
        status_word = 24'h00_0000;
        status_word[`STC_STAT_DONE_BIT] = cal_complete_flag_q && CAL_ENABLE_I;
        status_word[`STC_RES_INV_BIT:0] = cal.result;
    end

    always_comb begin
        rvalid_d = REG_RD_I;
        rdata_d  = 24'h00_0000;
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                `STC_ADDR_CFG:    rdata_d = {16'h0000, 4'h0, cal_average_count_q,
                                             cal_accumulation_length_q};
                `STC_ADDR_STATUS: rdata_d = status_word;
                default:          rdata_d = 24'h00_0000;
            endcase
        end
        // manual setting rules while calibration is off
        delay_d    = CAL_ENABLE_I ? cal.result : MANUAL_DELAY_I;
        busy_d     = cal.busy;
        fail_out_d = failed_q;
    end

    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rdata_q    <= 24'h00_0000;
            rvalid_q   <= 1'b0;
            delay_q    <= `STC_RESULT_RESET;
            busy_q     <= 1'b0;
            fail_out_q <= 1'b0;
        end else begin
            rdata_q    <= rdata_d;
            rvalid_q   <= rvalid_d;
            delay_q    <= delay_d;
            busy_q     <= busy_d;
            fail_out_q <= fail_out_d;
        end
    end

    assign REG_RDATA_O  = rdata_q;
    assign REG_RVALID_O = rvalid_q;
    assign DELAY_O      = delay_q;
    assign CAL_BUSY_O   = busy_q;
    assign CAL_FAILED_O = fail_out_q;
endmodule // stc_top

// ### verification/stc_sysref_src.sv
// partner model: periodic sysref source on the far side of the pin
// assumes periods given in sampling clock cycles of 40 ns
`timescale 1ns/100ps
module stc_sysref_src (
    input  wire logic        run_i,    // source running
    input  wire logic [15:0] period_i, // period, cycles
    input  wire logic [15:0] high_i,   // high time, cycles
    output logic             sysref_o  // sysref pin level
);
    int unsigned phase = 0;

    // odd start offset puts every edge 13 ns ahead of a rising clock edge, clear of it
    initial begin
        sysref_o = 1'b0;
        #7;
        forever begin
            // a shorter new period takes effect at once, not after the old one
            sysref_o = run_i && (phase < high_i);
            phase    = (!run_i || phase + 1 >= period_i) ? 0 : phase + 1;
            #40;
        end
    end
endmodule // stc_sysref_src

// ### verification/stc_top_props.sv
// checker for the sysref calibration top: register answers, enable, delay
// assumes one clock domain and bind by name from the bench
`timescale 1ns/100ps
`include "stc_consts.svh"
module stc_top_props #(
    parameter logic [31:0] CAL_SCALE = `STC_CAL_SCALE // time bound factor
) (
    input wire logic                   CLOCK_I,        // clock
    input wire logic                   RESET_N_I,      // reset
    input wire logic                   SYSREF_I,       // sysref pin
    input wire logic                   CAL_ENABLE_I,   // enable
    input wire logic [16:0]            MANUAL_DELAY_I, // manual delay
    input wire logic [`STC_ADDR_W-1:0] REG_ADDR_I,     // address
    input wire logic                   REG_WR_I,       // write strobe
    input wire logic [7:0]             REG_WDATA_I,    // write data
    input wire logic                   REG_RD_I,       // read strobe
    input wire logic [23:0]            REG_RDATA_O,    // read data
    input wire logic                   REG_RVALID_O,   // read valid
    input wire logic [16:0]            DELAY_O,        // applied delay
    input wire logic                   CAL_BUSY_O,     // busy
    input wire logic                   CAL_FAILED_O    // failed
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESET_N_I);

    sequence s_cfg_rd;
        REG_RD_I && REG_ADDR_I == `STC_ADDR_CFG;
    endsequence
    sequence s_stat_rd;
        REG_RD_I && REG_ADDR_I == `STC_ADDR_STATUS;
    endsequence

    property p_rd_answer;
        REG_RD_I |=> REG_RVALID_O;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_quiet;
        !REG_RD_I |=> !REG_RVALID_O && REG_RDATA_O == 24'h00_0000;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data without read");
    property p_cfg_upper;
        s_cfg_rd |=> REG_RDATA_O[23:4] == 20'h0_0000;
    endproperty
    a_cfg_upper: assert property (p_cfg_upper) else $error("config reserved set");
    property p_stat_resv;
        s_stat_rd |=> REG_RDATA_O[23:18] == 6'h00;
    endproperty
    a_stat_resv: assert property (p_stat_resv) else $error("status reserved set");
    property p_done_off;
        s_stat_rd ##0 !CAL_ENABLE_I |=> !REG_RDATA_O[`STC_STAT_DONE_BIT];
    endproperty
    a_done_off: assert property (p_done_off) else $error("done while disabled");
    property p_manual;
        RESET_N_I && !CAL_ENABLE_I |=> DELAY_O == $past(MANUAL_DELAY_I);
    endproperty
    a_manual: assert property (p_manual) else $error("manual delay not applied");
    property p_start;
        $rose(CAL_ENABLE_I) |-> ##2 CAL_BUSY_O;
    endproperty
    a_start: assert property (p_start) else $error("enable rise did not start");
    property p_abort;
        $fell(CAL_ENABLE_I) |-> ##[1:3] !CAL_BUSY_O;
    endproperty
    a_abort: assert property (p_abort) else $error("busy after disable");
    property p_fail_clr;
        $rose(CAL_ENABLE_I) |=> ##[0:1] !CAL_FAILED_O;
    endproperty
    a_fail_clr: assert property (p_fail_clr) else $error("failed kept on restart");
endmodule // stc_top_props

// ### verification/stc_top_test.sv
// self-checking bench for the sysref calibration top with a sysref source
// assumes a short time bound factor so bound failures come quickly
`timescale 1ns/100ps
`include "stc_consts.svh"
module stc_top_test;
    localparam logic [31:0] SCALE = 32'h0000_0004;
    logic        clock_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        sysref;
    logic        cal_en = 1'b0;
    logic [16:0] manual = 17'h1_2345;
    logic [11:0] addr = 12'h000;
    logic        wr = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic        rd = 1'b0;
    logic [23:0] rdata;
    logic        rvalid;
    logic [16:0] delay;
    logic        busy;
    logic        failed;
    logic        src_run = 1'b0;
    logic [15:0] src_per = 16'h0008;
    logic [15:0] src_high = 16'h0006;
    int          fail_count = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #20 clock_i = ~clock_i;

    stc_top #(.CAL_SCALE(SCALE)) uut (
        .CLOCK_I(clock_i), .RESET_N_I(reset_n_i), .SYSREF_I(sysref),
        .CAL_ENABLE_I(cal_en), .MANUAL_DELAY_I(manual), .REG_ADDR_I(addr),
        .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata),
        .REG_RVALID_O(rvalid), .DELAY_O(delay), .CAL_BUSY_O(busy),
        .CAL_FAILED_O(failed));
    stc_sysref_src src (.run_i(src_run), .period_i(src_per), .high_i(src_high),
        .sysref_o(sysref));

    task automatic test_done;
        if (fail_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // generous ceiling: longest run is a few thousand cycles
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
            fail_count++;
        end
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [11:0] a, output logic [23:0] d);
        @(posedge clock_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        #1;
        d = rdata;
        chk({23'h0, rvalid}, 24'h00_0001, "read valid");
    endtask

    task automatic set_en(input logic v);
        @(posedge clock_i);
        cal_en <= v;
    endtask

    task automatic t_regs;
        logic [23:0] d;
        rd_reg(`STC_ADDR_CFG, d);
        chk(d, 24'h00_0005, "config reset");
        rd_reg(`STC_ADDR_STATUS, d);
        chk(d & 24'hfe_0000, 24'h00_0000, "status reset");
        rd_reg(12'h02b3, d);
        chk(d, 24'h00_0000, "unmapped read");
        for (int i = 0; i < 4; i++) begin
            wr_reg(`STC_ADDR_CFG, 8'hf0 | 8'(i << 2) | 8'(3 - i));
            rd_reg(`STC_ADDR_CFG, d);
            chk(d, 24'(8'(i << 2) | 8'(3 - i)), "config fields");
        end
        wr_reg(`STC_ADDR_STATUS, 8'hff);
        rd_reg(`STC_ADDR_STATUS, d);
        chk(d & 24'hfe_0000, 24'h00_0000, "status write ignored");
    endtask

    // source stays high over a whole window, so every sample counts
    task automatic t_cal_ok(input logic [1:0] a, input logic [1:0] h,
                            input logic [15:0] per, input logic [15:0] hi);
        logic [23:0] d;
        logic [16:0] e;
        int          w;
        int          n;
        w = 4 << (2 * h);
        e = {1'b1, (w > 255) ? 8'hff : 8'(w), 8'h00};
        src_per <= per;
        src_high <= hi;
        src_run <= 1'b1;
        wr_reg(`STC_ADDR_CFG, {4'h0, a, h});
        set_en(1'b1);
        n = 0;
        do begin
            rd_reg(`STC_ADDR_STATUS, d);
            n++;
        end while (d[17] !== 1'b1 && n < 3000);
        chk(d, {6'h00, 1'b1, e}, "done and result");
        chk(24'(delay), 24'(e), "auto delay");
        chk({23'h0, failed}, 24'h00_0000, "no failure");
        set_en(1'b0);
        rd_reg(`STC_ADDR_STATUS, d);
        chk({23'h0, d[17]}, 24'h00_0000, "done cleared");
        chk(24'(delay), 24'(manual), "manual delay");
    endtask

    task automatic t_fail(input logic [1:0] a, input logic [15:0] per, input int lim);
        logic [23:0] d;
        int          n;
        src_per <= per;
        wr_reg(`STC_ADDR_CFG, {4'h0, a, 2'b00});
        set_en(1'b1);
        n = 0;
        while (failed !== 1'b1 && n < lim) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        chk({23'h0, failed}, 24'h00_0001, "failure in time");
        rd_reg(`STC_ADDR_STATUS, d);
        chk({23'h0, d[17]}, 24'h00_0000, "no done on failure");
        set_en(1'b0);
        repeat (4) @(posedge clock_i);
    endtask

    task automatic t_abort;
        set_en(1'b1);
        repeat (10) @(posedge clock_i);
        set_en(1'b0);
        repeat (4) @(posedge clock_i);
        #1;
        chk({23'h0, busy}, 24'h00_0000, "abort stops engine");
    endtask

    initial begin
        repeat (20) @(posedge clock_i);
        reset_n_i <= 1'b1;
        t_regs();
        // short periods keep every run inside the shortened time bound
        for (int h = 0; h < 4; h++)
            t_cal_ok(2'b00, 2'(h), 16'((4 << (2 * h)) + 4), 16'((4 << (2 * h)) + 2));
        for (int a = 1; a < 4; a++)
            t_cal_ok(2'(a), 2'b00, 16'h0008, 16'h0006);
        t_fail(2'b11, 16'h00c8, 600);
        t_fail(2'b00, 16'h0064, 16 * 4 + 4);
        t_abort();
        test_done();
    end
endmodule // stc_top_test

bind stc_top stc_top_props #(.CAL_SCALE(CAL_SCALE)) u_props (
    .CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .SYSREF_I(SYSREF_I),
    .CAL_ENABLE_I(CAL_ENABLE_I), .MANUAL_DELAY_I(MANUAL_DELAY_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_WDATA_I(REG_WDATA_I),
    .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O),
    .DELAY_O(DELAY_O), .CAL_BUSY_O(CAL_BUSY_O), .CAL_FAILED_O(CAL_FAILED_O));
